// >>> core/sbcd_pkg.sv
// package for the subtract-with-borrow / compare opcode decoder
// assumes bytes arrive one per accepted handshake from the fetch unit
package sbcd_pkg;

    // ------------------------------------------------------------
    // operation group: low nibble of the operation byte
    // ------------------------------------------------------------
    localparam logic [3:0] OPN_SUBTRACT_WITH_BORROW = 4'hB;
    localparam logic [3:0] OPN_CMP = 4'hF;

    // ------------------------------------------------------------
    // operation-byte high nibbles, with or without prefix (operation nibble in low half)
    // ------------------------------------------------------------
    localparam logic [3:0] B1_ACC_IMM_HI = 4'hA;
    localparam logic [3:0] HI_ACC_IMM = 4'hA;
    localparam logic [3:0] HI_ACC_SA1 = 4'h9;
    localparam logic [3:0] HI_REG_REG = 4'h8;
    localparam logic [3:0] HI_SA1_IMM = 4'h6;
    localparam logic [3:0] HI_REG_MISC = 4'h7;

    // ------------------------------------------------------------
    // prefix bytes
    // ------------------------------------------------------------
    localparam logic [7:0] PFX_AREA2 = 8'h3C;
    localparam logic [7:0] PFX_SFR = 8'h01;
    localparam logic [7:0] PFX_AREA_AREA = 8'h2A;
    localparam logic [7:0] PFX_ABS = 8'h0A;
    localparam logic [7:0] PFX_PTR = 8'h07;
    localparam logic [7:0] PFX_BYTE_OFS = 8'h06;
    localparam logic [7:0] PFX_PTR_IND = 8'h16;
    localparam logic [7:0] PFX_BASE_IDX = 8'h17;

    // ------------------------------------------------------------
    // second-byte high nibbles after a prefix
    // ------------------------------------------------------------
    localparam logic [3:0] MOD_IMMEDIATE_24BIT_OFFSET_LO = 4'h0;
    localparam logic [3:0] MOD_IMMEDIATE_24BIT_OFFSET_HI = 4'h3;
    localparam logic [3:0] MOD_ABS16 = 4'h4;
    localparam logic [3:0] MOD_ABS24 = 4'h5;
    localparam logic [3:0] MOD_ABS16_MEM = 4'hC;
    localparam logic [3:0] MOD_ABS24_MEM = 4'hD;
    localparam logic [3:0] MOD_PTR_SHORT = 4'h2;
    localparam logic [3:0] MOD_PTR_LONG = 4'h3;
    localparam logic [3:0] MOD_PTR_SHORT_MEM = 4'hA;
    localparam logic [3:0] MOD_PTR_LONG_MEM = 4'hB;
    localparam int MEM_DEST_BIT = 7;
    localparam int REG_SEP_BIT = 3;

    // ------------------------------------------------------------
    // decoded enumerations and result carrier
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SBCD_OP_NONE = 2'h0,
        SBCD_OP_SUBTRACT_WITH_BORROW = 2'h1,
        SBCD_OP_CMP = 2'h2
    } sbcd_op_e;

    typedef enum logic [3:0] {
        SBCD_AM_NONE = 4'h0,
        SBCD_AM_IMM = 4'h1,
        SBCD_AM_REG = 4'h2,
        SBCD_AM_AREA_ONE = 4'h3,
        SBCD_AM_AREA_TWO = 4'h4,
        SBCD_AM_SFR = 4'h5,
        SBCD_AM_ABS16 = 4'h6,
        SBCD_AM_ABS24 = 4'h7,
        SBCD_AM_PTR_IND = 4'h8,
        SBCD_AM_SHORT_PTR = 4'h9,
        SBCD_AM_LONG_PTR = 4'hA,
        SBCD_AM_BYTE_OFS = 4'hB,
        SBCD_AM_IMMEDIATE_24BIT_OFFSET_OFS = 4'hC,
        SBCD_AM_BASE_IDX = 4'hD,
        SBCD_AM_ACC = 4'hE
    } sbcd_am_e;

    typedef struct packed {
        sbcd_op_e op;
        sbcd_am_e dst;
        sbcd_am_e src;
        logic [3:0] dst_reg;
        logic [2:0] src_reg;
        logic [3:0] sel;
        logic wr_dst;
        logic use_carry;
        logic [2:0] len;
        logic [23:0] addr;
        logic [7:0] imm;
        logic [7:0] addr2;
        logic illegal;
    } sbcd_dec_s;

    localparam logic [2:0] LEN_MAX = 3'h6;
endpackage

// >>> core/sbcd_form.sv
// form lookup: from prefix and operation byte, operand modes and length
// assumes bytes are stable while examined; purely combinational
`timescale 1ns/10ps
module sbcd_form (
    input wire logic [7:0] pfx_i,
    input wire logic [7:0] opb_i,
    input wire logic has_pfx_i,
    input wire logic area2_i,
    output sbcd_pkg::sbcd_am_e dst_o,
    output sbcd_pkg::sbcd_am_e src_o,
    output logic [2:0] len_o,
    output logic known_o
);
    logic [3:0] hi;
    assign hi = opb_i[7:4];

    always_comb begin
        dst_o = sbcd_pkg::SBCD_AM_ACC;
        src_o = sbcd_pkg::SBCD_AM_NONE;
        len_o = 3'h0;
        known_o = 1'b1;
        if (!has_pfx_i) begin
            case (hi)
                sbcd_pkg::HI_ACC_IMM: begin
                    src_o = sbcd_pkg::SBCD_AM_IMM;
                    len_o = 3'h2;
                end
                sbcd_pkg::HI_ACC_SA1: begin
                    src_o = sbcd_pkg::SBCD_AM_AREA_ONE;
                    len_o = 3'h2;
                end
                sbcd_pkg::HI_REG_REG: begin
                    dst_o = sbcd_pkg::SBCD_AM_REG;
                    src_o = sbcd_pkg::SBCD_AM_REG;
                    len_o = 3'h2;
                end
                default: known_o = 1'b0;
            endcase
        end else begin
            case (pfx_i)
                sbcd_pkg::PFX_AREA2: begin
                    // area-two prefix only carries these second bytes here
                    // area-two with immediate
                    if (hi == sbcd_pkg::HI_SA1_IMM) begin
                        dst_o = sbcd_pkg::SBCD_AM_AREA_TWO;
                        src_o = sbcd_pkg::SBCD_AM_IMM;
                        len_o = 3'h4;
                    end else if (hi == sbcd_pkg::HI_REG_REG) begin
                        dst_o = sbcd_pkg::SBCD_AM_REG;
                        src_o = sbcd_pkg::SBCD_AM_REG;
                        len_o = 3'h3;
                    end else begin
                        known_o = 1'b0;
                    end
                end
                sbcd_pkg::PFX_SFR: begin
                    dst_o = sbcd_pkg::SBCD_AM_SFR;
                    src_o = sbcd_pkg::SBCD_AM_IMM;
                    len_o = 3'h4;
                    known_o = (hi == sbcd_pkg::HI_SA1_IMM);
                end
                sbcd_pkg::PFX_AREA_AREA: begin
                    dst_o = hi[1] ? sbcd_pkg::SBCD_AM_AREA_TWO : sbcd_pkg::SBCD_AM_AREA_ONE;
                    src_o = hi[0] ? sbcd_pkg::SBCD_AM_AREA_TWO : sbcd_pkg::SBCD_AM_AREA_ONE;
                    len_o = 3'h4;
                    known_o = (hi[3:2] == 2'h0);
                end
                sbcd_pkg::PFX_ABS: begin
                    case (hi)
                        sbcd_pkg::MOD_ABS16: begin
                            src_o = sbcd_pkg::SBCD_AM_ABS16;
                            len_o = 3'h4;
                        end
                        sbcd_pkg::MOD_ABS24: begin
                            src_o = sbcd_pkg::SBCD_AM_ABS24;
                            len_o = 3'h5;
                        end
                        sbcd_pkg::MOD_ABS16_MEM: begin
                            dst_o = sbcd_pkg::SBCD_AM_ABS16;
                            src_o = sbcd_pkg::SBCD_AM_ACC;
                            len_o = 3'h4;
                        end
                        sbcd_pkg::MOD_ABS24_MEM: begin
                            dst_o = sbcd_pkg::SBCD_AM_ABS24;
                            src_o = sbcd_pkg::SBCD_AM_ACC;
                            len_o = 3'h5;
                        end
                        default: begin
                            // 24-bit offset forms
                            // immediate_24bit_offset forms: bit 7 picks memory destination
                            len_o = 3'h5;
                            if (opb_i[sbcd_pkg::MEM_DEST_BIT]) begin
                                dst_o = sbcd_pkg::SBCD_AM_IMMEDIATE_24BIT_OFFSET_OFS;
                                src_o = sbcd_pkg::SBCD_AM_ACC;
                            end else begin
                                src_o = sbcd_pkg::SBCD_AM_IMMEDIATE_24BIT_OFFSET_OFS;
                            end
                            known_o = (opb_i[6:4] <= sbcd_pkg::MOD_IMMEDIATE_24BIT_OFFSET_HI[2:0]);
                        end
                    endcase
                end
                sbcd_pkg::PFX_PTR: begin
                    src_o = hi[0] ? sbcd_pkg::SBCD_AM_LONG_PTR : sbcd_pkg::SBCD_AM_SHORT_PTR;
                    // area-two prefix byte is added once, below
                    len_o = 3'h3;
                    known_o = (hi == sbcd_pkg::MOD_PTR_SHORT) || (hi == sbcd_pkg::MOD_PTR_LONG)
                        || (hi == sbcd_pkg::MOD_PTR_SHORT_MEM)
                        || (hi == sbcd_pkg::MOD_PTR_LONG_MEM);
                    if (opb_i[sbcd_pkg::MEM_DEST_BIT]) begin
                        dst_o = src_o;
                        src_o = sbcd_pkg::SBCD_AM_ACC;
                    end
                end
                sbcd_pkg::PFX_BYTE_OFS, sbcd_pkg::PFX_PTR_IND, sbcd_pkg::PFX_BASE_IDX: begin
                    src_o = (pfx_i == sbcd_pkg::PFX_BYTE_OFS) ? sbcd_pkg::SBCD_AM_BYTE_OFS
                        : (pfx_i == sbcd_pkg::PFX_PTR_IND) ? sbcd_pkg::SBCD_AM_PTR_IND
                        : sbcd_pkg::SBCD_AM_BASE_IDX;
                    len_o = (pfx_i == sbcd_pkg::PFX_BYTE_OFS) ? 3'h3 : 3'h2;
                    known_o = (pfx_i != sbcd_pkg::PFX_BYTE_OFS) || (opb_i[6:4] <= 3'h4);
                    if (opb_i[sbcd_pkg::MEM_DEST_BIT]) begin
                        dst_o = src_o;
                        src_o = sbcd_pkg::SBCD_AM_ACC;
                    end
                end
                default: known_o = 1'b0;
            endcase
            if (area2_i && pfx_i != sbcd_pkg::PFX_AREA2) begin
                len_o = 3'(len_o + 3'h1);
            end
        end
    end
endmodule

// >>> core/sbcd_decoder.sv
// subtract-with-borrow and compare opcode decoder, byte-serial
// assumes the fetch unit offers one opcode byte per valid/ready beat
// Behaviour
// - AF then immediate byte: compare accumulator with immediate, two bytes.
// - 9F then offset: compare accumulator with area-one location.
// - 01 6F, area offset, immediate: compare special area with immediate.
// - 3C 6F, offset, immediate: compare area-two location with immediate.
// - 3C 8F then register byte: dest bits 7-4, zero, source 2-0.
// - 2A 0F, second offset then first offset: area-one to area-one compare.
// - 0A 4F: compare accumulator with 16-bit address, low byte first.
// - 0A 5F: compare with 24-bit address, highest byte then low, high.
// - 0A CF: memory-first compare at 16-bit address, low then high.
// - 17 0F: based-indexed compare, first pair plus accumulator, two bytes.
// - 0A 0F: compare with 24-bit offset base, low, high, highest.
// - 07 3F then offset: compare accumulator with long pointer location.
// - 3C 07 BB then offset: borrow-subtract into area-two long pointer.
// - 0A 5B: borrow-subtract 24-bit address byte, highest, low, high.
// - 0A CB then low, high: borrow-subtract into 16-bit address.
// - 06 1B then one offset: borrow-subtract stack pointer plus byte.
// - 0A 2B then three offset bytes low to highest.
// - 16 8B: memory destination, first pointer post-increment; bit 7 selects.
// - 0A 8B then low, high, highest: memory destination, immediate_24bit_offset offset.
// - 17 DB: memory destination, third pointer plus register pair.
`timescale 1ns/10ps
module sbcd_decoder (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_valid_i,
    output logic byte_ready_o,
    output sbcd_pkg::sbcd_dec_s dec_o,
    output logic dec_valid_o,
    input wire logic dec_ready_i
);
    // ------------------------------------------------------------
    // state and byte collection
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SBCD_ST_FIRST = 4'b0001,
        SBCD_ST_SECOND = 4'b0010,
        SBCD_ST_TAIL = 4'b0100,
        SBCD_ST_DONE = 4'b1000
    } sbcd_state_e;

    sbcd_state_e state_reg;
    logic [7:0] pfx_reg;
    logic has_pfx_reg;
    logic area2_reg;
    logic [7:0] opb_reg;
    logic [2:0] cnt_reg;
    logic [7:0] tail_reg [0:3];
    sbcd_pkg::sbcd_dec_s dec_reg;
    sbcd_pkg::sbcd_dec_s dec_next;
    sbcd_pkg::sbcd_am_e f_dst;
    sbcd_pkg::sbcd_am_e f_src;
    logic [2:0] f_len;
    logic f_known;
    logic beat;
    logic op_byte;
    logic [2:0] taken;
    logic [3:0] lo_nib;
    logic tail_end;

    assign beat = ce_i && byte_valid_i && byte_ready_o;
    // no buffering: one instruction in flight, next waits for dec_ready_i
    // a byte offered in the closing tail cycle would be lost, so refuse it
    assign tail_end = (state_reg == SBCD_ST_TAIL) && (taken >= f_len || !f_known);
    assign byte_ready_o = (state_reg != SBCD_ST_DONE) && !tail_end;
    assign dec_valid_o = (state_reg == SBCD_ST_DONE);
    assign dec_o = dec_reg;
    assign lo_nib = byte_i[3:0];
    // a first byte with an operation nibble and a high nibble above 1 ends the prefix chain
    assign op_byte = (lo_nib == sbcd_pkg::OPN_SUBTRACT_WITH_BORROW) || (lo_nib == sbcd_pkg::OPN_CMP);
    // area-two prefix counts extra only when a pointer prefix followed it
    assign taken = 3'(cnt_reg + (has_pfx_reg ? 3'h2 : 3'h1)
        + ((area2_reg && pfx_reg != sbcd_pkg::PFX_AREA2) ? 3'h1 : 3'h0));

    sbcd_form u_form (
        .pfx_i(pfx_reg),
        .opb_i(opb_reg),
        .has_pfx_i(has_pfx_reg),
        .area2_i(area2_reg),
        .dst_o(f_dst),
        .src_o(f_src),
        .len_o(f_len),
        .known_o(f_known)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= SBCD_ST_FIRST;
            has_pfx_reg <= 1'b0;
            area2_reg <= 1'b0;
            pfx_reg <= 8'h00;
            opb_reg <= 8'h00;
            cnt_reg <= 3'h0;
        end else if (ce_i) begin
            case (state_reg)
                SBCD_ST_FIRST: begin
                    if (beat) begin
                        if (byte_i == sbcd_pkg::PFX_AREA2 && !area2_reg) begin
                            area2_reg <= 1'b1;
                            has_pfx_reg <= 1'b1;
                            pfx_reg <= byte_i;
                            state_reg <= SBCD_ST_SECOND;
                        end else if (op_byte && byte_i[7:4] != 4'h0 && byte_i[7:4] != 4'h1) begin
                            opb_reg <= byte_i;
                            has_pfx_reg <= 1'b0;
                            cnt_reg <= 3'h0;
                            state_reg <= SBCD_ST_TAIL;
                        end else begin
                            pfx_reg <= byte_i;
                            has_pfx_reg <= 1'b1;
                            state_reg <= SBCD_ST_SECOND;
                        end
                    end
                end
                SBCD_ST_SECOND: begin
                    if (beat) begin
                        if (area2_reg && pfx_reg == sbcd_pkg::PFX_AREA2 && byte_i == sbcd_pkg::PFX_PTR) begin
                            pfx_reg <= byte_i;
                        end else begin
                            opb_reg <= byte_i;
                            cnt_reg <= 3'h0;
                            state_reg <= SBCD_ST_TAIL;
                        end
                    end
                end
                SBCD_ST_TAIL: begin
                    if (taken >= f_len || !f_known) begin
                        state_reg <= SBCD_ST_DONE;
                    end else if (beat) begin
                        cnt_reg <= 3'(cnt_reg + 3'h1);
                    end
                end
                SBCD_ST_DONE: begin
                    if (dec_ready_i) begin
                        state_reg <= SBCD_ST_FIRST;
                        area2_reg <= 1'b0;
                        has_pfx_reg <= 1'b0;
                    end
                end
                default: state_reg <= SBCD_ST_FIRST;
            endcase
        end
    end

    // ------------------------------------------------------------
    // operand bytes, one entry per tail position
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_tail
            always_ff @(posedge clk_i) begin
                if (!resetn_i) begin
                    tail_reg[gi] <= 8'h00;
                end else if (ce_i && beat && state_reg == SBCD_ST_TAIL && cnt_reg == 3'(gi)) begin
                    tail_reg[gi] <= byte_i;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // result assembly
    // ------------------------------------------------------------
    always_comb begin
        dec_next = '0;
        dec_next.dst = f_dst;
        dec_next.src = f_src;
        dec_next.len = f_len;
        dec_next.illegal = !f_known;
        dec_next.sel = opb_reg[7:4];
        case (opb_reg[3:0])
            sbcd_pkg::OPN_SUBTRACT_WITH_BORROW: dec_next.op = sbcd_pkg::SBCD_OP_SUBTRACT_WITH_BORROW;
            sbcd_pkg::OPN_CMP: dec_next.op = sbcd_pkg::SBCD_OP_CMP;
            default: begin
                dec_next.op = sbcd_pkg::SBCD_OP_NONE;
                dec_next.illegal = 1'b1;
            end
        endcase
        dec_next.wr_dst = (dec_next.op == sbcd_pkg::SBCD_OP_SUBTRACT_WITH_BORROW);
        dec_next.use_carry = (dec_next.op == sbcd_pkg::SBCD_OP_SUBTRACT_WITH_BORROW);
        if (f_src == sbcd_pkg::SBCD_AM_REG) begin
            dec_next.dst_reg = tail_reg[0][7:4];
            dec_next.src_reg = tail_reg[0][2:0];
            dec_next.illegal = dec_next.illegal | tail_reg[0][sbcd_pkg::REG_SEP_BIT];
        end
        if (f_src == sbcd_pkg::SBCD_AM_ABS24 || f_dst == sbcd_pkg::SBCD_AM_ABS24) begin
            // highest byte first, then low, high
            dec_next.addr = {tail_reg[0], tail_reg[2], tail_reg[1]};
        end else if (f_src == sbcd_pkg::SBCD_AM_IMMEDIATE_24BIT_OFFSET_OFS || f_dst == sbcd_pkg::SBCD_AM_IMMEDIATE_24BIT_OFFSET_OFS) begin
            dec_next.addr = {tail_reg[2], tail_reg[1], tail_reg[0]};
        end else begin
            dec_next.addr = {8'h00, tail_reg[1], tail_reg[0]};
        end
        dec_next.imm = (f_len == 3'h2) ? tail_reg[0] : tail_reg[1];
        // second operand offset first, first operand offset second
        dec_next.addr2 = tail_reg[1];
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dec_reg <= '0;
        end else if (ce_i && state_reg == SBCD_ST_TAIL && (taken >= f_len || !f_known)) begin
            dec_reg <= dec_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cmp_no_write;
        @(posedge clk_i) disable iff (!resetn_i)
        dec_valid_o && dec_o.op == sbcd_pkg::SBCD_OP_CMP |-> !dec_o.wr_dst;
    endproperty
    a_cmp_no_write: assert property (p_cmp_no_write) else $error("compare writes");

    property p_subtract_with_borrow_write;
        @(posedge clk_i) disable iff (!resetn_i)
        dec_valid_o && dec_o.op == sbcd_pkg::SBCD_OP_SUBTRACT_WITH_BORROW |-> dec_o.wr_dst && dec_o.use_carry;
    endproperty
    a_subtract_with_borrow_write: assert property (p_subtract_with_borrow_write) else $error("borrow-subtract no write");

    property p_len_bound;
        @(posedge clk_i) disable iff (!resetn_i)
        dec_valid_o && !dec_o.illegal |-> dec_o.len >= 3'h2 && dec_o.len <= sbcd_pkg::LEN_MAX;
    endproperty
    a_len_bound: assert property (p_len_bound) else $error("bad length");

    property p_done_holds;
        @(posedge clk_i) disable iff (!resetn_i)
        dec_valid_o && !dec_ready_i && ce_i |=> dec_valid_o && $stable(dec_o);
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("result dropped");

    property p_no_take_done;
        @(posedge clk_i) disable iff (!resetn_i)
        dec_valid_o |-> !byte_ready_o;
    endproperty
    a_no_take_done: assert property (p_no_take_done) else $error("byte taken while busy");

    property p_base_idx_len;
        @(posedge clk_i) disable iff (!resetn_i)
        dec_valid_o && (dec_o.src == sbcd_pkg::SBCD_AM_BASE_IDX
            || dec_o.dst == sbcd_pkg::SBCD_AM_BASE_IDX) |-> dec_o.len == 3'h2;
    endproperty
    a_base_idx_len: assert property (p_base_idx_len) else $error("based-indexed length");

    c_cmp: cover property (@(posedge clk_i) dec_valid_o && dec_o.op == sbcd_pkg::SBCD_OP_CMP);
    c_subtract_with_borrow: cover property (@(posedge clk_i) dec_valid_o && dec_o.op == sbcd_pkg::SBCD_OP_SUBTRACT_WITH_BORROW);
    c_long: cover property (@(posedge clk_i) dec_valid_o && dec_o.len == 3'h5);
endmodule

// >>> test/sbcd_fetch_model.sv
// fetch unit model: hands queued opcode bytes over a valid/ready beat
// assumes byte_ready_i already carries the decoder clock enable
`timescale 1ns/10ps
module sbcd_fetch_model (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic slow_i,
    input wire logic byte_ready_i,
    output logic [7:0] byte_o,
    output logic byte_valid_o
);
    logic [7:0] q[$];
    logic gap, offer;
    initial {byte_o, byte_valid_o} = 9'h000;
    task automatic push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // slow mode idles a cycle after each beat; idle data is inverted so no stale byte lingers
    always @(posedge clk_i) begin
        gap = slow_i && byte_valid_o && byte_ready_i;
        if (!resetn_i) q.delete();
        else if (byte_valid_o && byte_ready_i) void'(q.pop_front());
        offer = resetn_i && q.size() > 0 && !gap;
        byte_valid_o <= offer;
        byte_o <= offer ? q[0] : ~byte_o;
    end
endmodule

// >>> test/sbcd_decoder_tb.sv
// bench for the byte-serial opcode decoder
// assumes the fetch model and the core package are compiled before it
`timescale 1ns/10ps
module sbcd_decoder_tb;
    localparam sbcd_pkg::sbcd_op_e CMP = sbcd_pkg::SBCD_OP_CMP;
    localparam sbcd_pkg::sbcd_op_e SBC = sbcd_pkg::SBCD_OP_SUBTRACT_WITH_BORROW;
    logic clk_i, resetn_i, ce_i, dec_ready_i, slow, valid_w, byte_ready_o, dec_valid_o;
    logic [7:0] byte_w;
    sbcd_pkg::sbcd_dec_s dec_o, got;
    int mismatches = 0, samples_checked = 0;
    sbcd_decoder dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .byte_i(byte_w),
        .byte_valid_i(valid_w), .byte_ready_o(byte_ready_o), .dec_o(dec_o),
        .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready_i));
    sbcd_fetch_model fetch (.clk_i(clk_i), .resetn_i(resetn_i), .slow_i(slow),
        .byte_ready_i(byte_ready_o & ce_i), .byte_o(byte_w), .byte_valid_o(valid_w));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string m);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic feed(input logic [39:0] b, input int n);
        for (int k = n - 1; k >= 0; k--)
            fetch.push(b[8 * k +: 8]);
    endtask
    task automatic collect(input int n, input sbcd_pkg::sbcd_op_e op, input logic ill = 1'h0);
        for (int k = 0; k < 40 && dec_valid_o !== 1'h1; k++) @(negedge clk_i);
        got = dec_o;
        check({dec_valid_o, got.illegal, got.op, got.len}, {1'h1, ill, op, 3'(n)}, "op");
        check({got.wr_dst, got.use_carry}, {2{op == SBC}}, "effect");
        @(posedge clk_i);
        dec_ready_i <= 1'h1;
        @(posedge clk_i);
        dec_ready_i <= 1'h0;
        #1;
    endtask
    task automatic run(input logic [39:0] b, input int n, input sbcd_pkg::sbcd_op_e op);
        feed(b, n);
        collect(n, op);
    endtask
    task automatic t_forms();
        run(40'hAF5A, 2, CMP);
        run(40'h9F20, 2, CMP);
        run(40'h016F33C4, 4, CMP);
        check(got.imm, 8'hC4, "imm");
        run(40'h3C6F44D2, 4, CMP);
        check(got.imm, 8'hD2, "imm");
        run(40'h3C8FA5, 3, CMP);
        check({got.dst_reg, got.src_reg}, 7'h55, "regs");
        feed(40'h3C8FA8, 3);
        collect(3, CMP, 1'h1);
        run(40'h2A0F3132, 4, CMP);
        check({got.addr[7:0], got.addr2}, 16'h3132, "offsets");
        run(40'h0A4F3412, 4, CMP);
        check(got.addr[15:0], 16'h1234, "addr");
        run(40'h0A5F0E3412, 5, CMP);
        check(got.addr, 24'h0E1234, "addr");
        run(40'h0ACF7856, 4, CMP);
        run(40'h170F, 2, CMP);
        run(40'h0A0F112233, 5, CMP);
        check(got.addr, 24'h332211, "offset");
        run(40'h073F40, 3, CMP);
        run(40'h3C07BB41, 4, SBC);
        run(40'h0A5B0C2143, 5, SBC);
        run(40'h0ACB9A78, 4, SBC);
        run(40'h061B42, 3, SBC);
        run(40'h0A2B445566, 5, SBC);
        run(40'h168B, 2, SBC);
        check({got.dst, got.src}, {sbcd_pkg::SBCD_AM_PTR_IND, sbcd_pkg::SBCD_AM_ACC}, "mem");
        run(40'h0A8B778899, 5, SBC);
        run(40'h17DB, 2, SBC);
    endtask
    task automatic t_hold();
        slow = 1'h1;
        feed(40'hAF119F22, 4);
        repeat (8) @(posedge clk_i);
        ce_i <= 1'h0;
        dec_ready_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        ce_i <= 1'h1;
        dec_ready_i <= 1'h0;
        #1;
        check({dec_valid_o, byte_ready_o, dec_o.imm}, 10'h211, "held");
        collect(2, CMP);
        collect(2, CMP);
        feed(40'h0A4F, 2);
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'h0;
        @(posedge clk_i);
        resetn_i <= 1'h1;
        #1;
        check({dec_valid_o, byte_ready_o}, 2'h1, "reset");
        run(40'h170F, 2, CMP);
    endtask
    initial begin
        {resetn_i, ce_i, dec_ready_i, slow} = 4'h4;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'h1;
        #1;
        t_forms();
        t_hold();
        end_sim();
    end
    initial begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        #500000;
        mismatches++;
        end_sim();
    end
endmodule
